// file: core/bdu_access_guard.sv
`timescale 1ns/1ps
`include "bdu_regs.svh"

module bdu_access_guard (
   // access context
   input  wire logic                cpl_zero,
   input  wire logic                real_mode,
   input  wire logic                guard_bit,
   // verdict
   output bdu_pkg::bdu_verdict_e    verdict
);
   import bdu_pkg::*;

   // privilege first, then the guard bit; real mode counts as level 0
   always_comb begin
      if (!(cpl_zero || real_mode)) begin
         verdict = BDU_ACC_PRIV_FAULT;
      end else if (guard_bit) begin
         verdict = BDU_ACC_GUARD_FAULT;
      end else begin
         verdict = BDU_ACC_GRANT;
      end
   end
endmodule

// file: core/bdu_bp_match.sv
`timescale 1ns/1ps
`include "bdu_regs.svh"

module bdu_bp_match (
   // breakpoint setup
   input  wire logic [31:0]         bp_addr,
   input  wire logic [1:0]          acc_type,
   input  wire logic [1:0]          watch_len,
   // accesses
   input  bdu_pkg::bdu_exec_s       exec_in,
   input  bdu_pkg::bdu_data_s       data_in,
   // raw matches, enables not applied
   output logic                     code_hit,
   output logic                     data_hit
);
   import bdu_pkg::*;

   // byte lanes of a dword touched by an address and a size code;
   // a watch drops the low address bits its length covers, an access keeps them
   function automatic logic [3:0] lane_mask(input logic [1:0] lo, input logic [1:0] len,
                                            input logic align);
      logic [1:0] base;
      logic [3:0] m;
      base = align ? (lo & ~len) : lo;
      m    = 4'h0;
      unique case (len)
         `BDU_LEN_1: m = 4'h1 << base;
         `BDU_LEN_2: m = 4'h3 << base;
         `BDU_LEN_4: m = 4'hF << base;
         default:    m = 4'h0; // unused code watches nothing
      endcase
      return m;
   endfunction

   logic [3:0] bp_lanes;
   logic [3:0] acc_lanes;
   logic       same_dword;

   // range compare on dword plus lanes; a split access only checks its first dword
   always_comb begin
      bp_lanes   = lane_mask(bp_addr[1:0], watch_len, 1'b1);
      acc_lanes  = lane_mask(data_in.lin_addr[1:0], data_in.size, 1'b0);
      same_dword = (data_in.lin_addr[31:2] == bp_addr[31:2]);
   end

   // trigger selected by the access-type field
   always_comb begin
      code_hit = exec_in.valid && (acc_type == `BDU_TYPE_EXEC)
                 && (exec_in.lin_addr == bp_addr);
      data_hit = data_in.valid && same_dword && |(bp_lanes & acc_lanes)
                 && ((acc_type == `BDU_TYPE_RDWR)
                     || (acc_type == `BDU_TYPE_WRITE && data_in.write));
   end
endmodule

// file: core/bdu_debug_unit.sv
`timescale 1ns/1ps
`include "bdu_regs.svh"

module bdu_debug_unit #(
   parameter int unsigned NUM_BP = 4
) (
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                srst,
   // move-instruction register port
   input  bdu_pkg::bdu_reg_req_s    reg_req,
   input  wire logic [1:0]          cpl,
   input  wire logic                real_mode,
   output bdu_pkg::bdu_reg_rsp_s    reg_rsp,
   // pipeline events
   input  bdu_pkg::bdu_exec_s       exec_in,
   input  bdu_pkg::bdu_data_s       data_in,
   input  wire logic                instr_done,
   input  wire logic                trap_flag,
   input  wire logic                brk_instr,
   input  wire logic                task_switch,
   input  wire logic                task_trap_bit,
   // exceptions to the core
   output bdu_pkg::bdu_exc_s        dbg_exc,
   output logic                     brk_exc
);
   import bdu_pkg::*;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // control and status layouts only have room for four breakpoints
   // the guard sits at 13 and the fields start at 16, fixed by the layout
   if (NUM_BP != 4) begin : g_bad_count
      $error("bdu_debug_unit: NUM_BP must be 4");
   end

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   // move indices 0 up to NUM_BP-1 name the address registers
   // index 4 and 5 fall through to the unmapped case
   function automatic logic names_bp(input logic [2:0] idx);
      return idx < 3'(NUM_BP);
   endfunction

   // ****************************************************************
   // storage
   // ****************************************************************
   // control, status and address registers
   logic [31:0]    ctl_q;
   logic [31:0]    ctl_d;
   logic [31:0]    sts_q;
   logic [31:0]    sts_d;
   logic [31:0]    bp_q [NUM_BP];
   // registered answers, so every output leaves a flop
   bdu_reg_rsp_s   rsp_q;
   bdu_reg_rsp_s   rsp_d;
   bdu_exc_s       exc_q;
   bdu_exc_s       exc_d;
   logic           brk_q;

   // ****************************************************************
   // access decode
   // ****************************************************************
   bdu_verdict_e   verdict;
   logic           granted;
   logic           wr_ctl;
   logic           wr_sts;
   logic           wr_bp;
   logic           guard_exc;

   // privilege is judged before the guard bit, so a user-level probe
   // cannot clear the guard: a privilege fault raises no debug exception
   bdu_access_guard u_guard (
      .cpl_zero  (cpl == 2'h0),
      .real_mode (real_mode),
      .guard_bit (ctl_q[`BDU_CTL_GUARD_BIT]),
      .verdict   (verdict)
   );

   // only a granted move writes the registers; a guard-faulted one still clears the guard bit
   // a refused move still gets its one-cycle answer, with the fault bit
   // writes to the holes at 4 and 5 are dropped without a fault
   always_comb begin
      granted   = reg_req.valid && (verdict == BDU_ACC_GRANT);
      guard_exc = reg_req.valid && (verdict == BDU_ACC_GUARD_FAULT);
      wr_ctl    = granted && reg_req.write && (reg_req.index == `BDU_IDX_CONTROL);
      wr_sts    = granted && reg_req.write && (reg_req.index == `BDU_IDX_STATUS);
      wr_bp     = granted && reg_req.write && names_bp(reg_req.index);
   end

   // ****************************************************************
   // breakpoint comparators
   // ****************************************************************
   logic [NUM_BP-1:0] code_hit;
   logic [NUM_BP-1:0] data_hit;
   logic [NUM_BP-1:0] bp_enabled;

   // all four compare every cycle; hits are raw and enables come later,
   // so that disabled matches can still be reported
   for (genvar n = 0; n < NUM_BP; n++) begin : g_bp
      bdu_bp_match u_match (
         .bp_addr   (bp_q[n]),
         .acc_type  (ctl_q[`BDU_CTL_TYPE_LSB(n) +: 2]),
         .watch_len (ctl_q[`BDU_CTL_LEN_LSB(n) +: 2]),
         .exec_in   (exec_in),
         .data_in   (data_in),
         .code_hit  (code_hit[n]),
         .data_hit  (data_hit[n])
      );
      // either enable arms the breakpoint
      assign bp_enabled[n] = ctl_q[`BDU_CTL_LOCAL_BIT(n)]
                             | ctl_q[`BDU_CTL_GLOBAL_BIT(n)];
   end

   // ****************************************************************
   // exception causes
   // ****************************************************************
   logic           code_exc;
   logic           data_exc;
   logic           step_exc;
   logic           task_exc;
   logic           any_exc;

   // a disabled match never raises, and is recorded only alongside a raised exception
   // causes are not prioritised: several in one cycle merge into one report,
   // and the handler sorts them out from the status flags
   always_comb begin
      code_exc = |(code_hit & bp_enabled);
      data_exc = |(data_hit & bp_enabled);
      step_exc = instr_done && trap_flag;
      task_exc = task_switch && task_trap_bit;
      any_exc  = code_exc || data_exc || step_exc || task_exc || guard_exc;
   end

   // exception report, registered so the core sees a clean pulse
   // hits ride along only when something raised, else a stray match
   // would look like an exception to the core
   always_comb begin
      exc_d           = '0;
      exc_d.valid     = any_exc;
      exc_d.fault     = code_exc || guard_exc;
      exc_d.hits      = any_exc ? (code_hit | data_hit) : 4'h0;
      exc_d.step      = step_exc;
      exc_d.task_trap = task_exc;
      exc_d.guard     = guard_exc;
   end

   // one-cycle report to the core
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         exc_q <= '0;
      end else begin
         exc_q <= exc_d;
      end
   end

   // breakpoint instruction is its own exception, code-breakpoint style
   // it bypasses the comparators, so no enable or status bit is involved
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         brk_q <= 1'b0;
      end else begin
         brk_q <= brk_instr;
      end
   end

   // ****************************************************************
   // address registers
   // ****************************************************************
   // plain storage of the watched linear addresses
   // no alignment is forced here; the comparator masks low bits by length
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < NUM_BP; i++) begin
            bp_q[i] <= `BDU_BP_RESET;
         end
      end else if (wr_bp) begin
         bp_q[reg_req.index[1:0]] <= reg_req.wdata;
      end
   end

   // ****************************************************************
   // control register
   // ****************************************************************
   // reserved bits are forced so software cannot move them
   // later lines win: a task switch beats a same-cycle write, and an
   // exception clears the guard even if that write just set it
   always_comb begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d = (reg_req.wdata & `BDU_CTL_WMASK) | `BDU_CTL_FIXED;
      end
      if (task_switch) begin
         ctl_d = ctl_d & ~`BDU_CTL_LOCAL_MASK;
      end
      if (any_exc) begin
         ctl_d[`BDU_CTL_GUARD_BIT] = 1'b0;
      end
   end

   // control flop; reset leaves every breakpoint disarmed
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctl_q <= `BDU_CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // ****************************************************************
   // status register
   // ****************************************************************
   logic [31:0]    sts_set;

   // flags accumulate; only software ever clears them
   // nothing is set unless an exception is really raised this cycle
   always_comb begin
      sts_set = 32'h0000_0000;
      if (any_exc) begin
         sts_set[3:0]               = code_hit | data_hit;
         sts_set[`BDU_STS_STEP_BIT] = step_exc;
         sts_set[`BDU_STS_TASK_BIT] = task_exc;
      end
   end

   // a same-cycle set beats the software write
   // software clears by writing zeros; a flag raised in that very cycle
   // survives, so no event is ever lost
   always_comb begin
      sts_d = sts_q;
      if (wr_sts) begin
         sts_d = reg_req.wdata & `BDU_STS_WMASK;
      end
      sts_d = sts_d | sts_set;
   end

   // status flop
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sts_q <= `BDU_STS_RESET;
      end else begin
         sts_q <= sts_d;
      end
   end

   // ****************************************************************
   // response path
   // ****************************************************************
   // read data shows the register value before this cycle's update
   // refused and write accesses answer with zero data
   // index holes 4 and 5 read zero; they fault on privilege or guard like any other index
   always_comb begin
      rsp_d          = '0;
      rsp_d.valid    = reg_req.valid;
      rsp_d.gp_fault = reg_req.valid && (verdict == BDU_ACC_PRIV_FAULT);
      rsp_d.db_fault = guard_exc;
      if (granted && !reg_req.write) begin
         unique case (reg_req.index)
            `BDU_IDX_BP0,
            `BDU_IDX_BP1,
            `BDU_IDX_BP2,
            `BDU_IDX_BP3:     rsp_d.rdata = bp_q[reg_req.index[1:0]];
            `BDU_IDX_STATUS:  rsp_d.rdata = sts_q;
            `BDU_IDX_CONTROL: rsp_d.rdata = ctl_q;
            default:          rsp_d.rdata = 32'h0000_0000; // unmapped index
         endcase
      end
   end

   // answer flop; stands one cycle after each request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // straight from the flops, no logic after them
   // brk_exc stays apart from dbg_exc: the core takes it on its own vector
   assign reg_rsp = rsp_q;
   assign dbg_exc = exc_q;
   assign brk_exc = brk_q;

endmodule

// file: core/bdu_pkg.sv
package bdu_pkg;

   // ****************************************************************
   // carriers
   // ****************************************************************
   // move-instruction access to a debug register
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [2:0]  index;
      logic [31:0] wdata;
   } bdu_reg_req_s;

   typedef struct packed {
      logic        valid;
      logic        gp_fault;
      logic        db_fault;
      logic [31:0] rdata;
   } bdu_reg_rsp_s;

   // instruction about to execute
   typedef struct packed {
      logic        valid;
      logic [31:0] lin_addr;
   } bdu_exec_s;

   // data access, size coded like the length field
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] lin_addr;
   } bdu_data_s;

   // debug exception report to the core
   typedef struct packed {
      logic        valid;
      logic        fault;
      logic [3:0]  hits;
      logic        step;
      logic        task_trap;
      logic        guard;
   } bdu_exc_s;

   typedef enum logic [1:0] {
      BDU_ACC_GRANT,
      BDU_ACC_PRIV_FAULT,
      BDU_ACC_GUARD_FAULT
   } bdu_verdict_e;

endpackage

// file: core/bdu_regs.svh
`ifndef BDU_REGS_SVH
`define BDU_REGS_SVH

// ****************************************************************
// register indices as named by the move instruction
// ****************************************************************
`define BDU_IDX_BP0          3'h0
`define BDU_IDX_BP1          3'h1
`define BDU_IDX_BP2          3'h2
`define BDU_IDX_BP3          3'h3
`define BDU_IDX_STATUS       3'h6
`define BDU_IDX_CONTROL      3'h7

// ****************************************************************
// control register layout
// ****************************************************************
`define BDU_CTL_LOCAL_BIT(n)   (2*(n))
`define BDU_CTL_GLOBAL_BIT(n)  (2*(n)+1)
`define BDU_CTL_GUARD_BIT      13
`define BDU_CTL_TYPE_LSB(n)    (16+4*(n))
`define BDU_CTL_LEN_LSB(n)     (18+4*(n))
`define BDU_CTL_LOCAL_MASK     32'h0000_0055
`define BDU_CTL_WMASK          32'hFFFF_20FF
`define BDU_CTL_FIXED          32'h0000_0400
`define BDU_CTL_RESET          32'h0000_0400

// ****************************************************************
// status register layout
// ****************************************************************
`define BDU_STS_STEP_BIT       14
`define BDU_STS_TASK_BIT       15
`define BDU_STS_WMASK          32'h0000_C00F
`define BDU_STS_RESET          32'h0000_0000
`define BDU_BP_RESET           32'h0000_0000

// ****************************************************************
// field encodings
// ****************************************************************
`define BDU_TYPE_EXEC          2'h0
`define BDU_TYPE_WRITE         2'h1
`define BDU_TYPE_RDWR          2'h3
`define BDU_LEN_1              2'h0
`define BDU_LEN_2              2'h1
`define BDU_LEN_4              2'h3

`endif

// file: dv/bdu_debug_unit_sva.sv
`timescale 1ns/1ps

module bdu_debug_unit_sva
   import bdu_pkg::*;
(
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          srst,
   // register port
   input bdu_reg_req_s       reg_req,
   input wire logic [1:0]    cpl,
   input wire logic          real_mode,
   input bdu_reg_rsp_s       reg_rsp,
   // pipeline events
   input bdu_exec_s          exec_in,
   input bdu_data_s          data_in,
   input wire logic          instr_done,
   input wire logic          trap_flag,
   input wire logic          brk_instr,
   input wire logic          task_switch,
   input wire logic          task_trap_bit,
   // exceptions
   input bdu_exc_s           dbg_exc,
   input wire logic          brk_exc
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // ****************************************************************
   // register port
   // ****************************************************************
   property p_rsp_next; reg_req.valid |=> reg_rsp.valid; endproperty
   a_rsp_next: assert property (p_rsp_next) else $error("no answer to request");
   property p_rsp_cause; reg_rsp.valid |-> $past(reg_req.valid); endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");
   property p_priv;
      reg_req.valid && cpl != 2'h0 && !real_mode |=> reg_rsp.gp_fault && reg_rsp.rdata == '0;
   endproperty
   a_priv: assert property (p_priv) else $error("privilege not enforced");
   // only a guard-free read can show the fixed middle byte
   property p_ctl_fixed;
      (reg_req.valid && !reg_req.write && reg_req.index == 3'h7 && (cpl == 2'h0 || real_mode))
      ##1 !reg_rsp.db_fault |-> reg_rsp.rdata[15:8] == 8'h04;
   endproperty
   a_ctl_fixed: assert property (p_ctl_fixed) else $error("reserved control bits wrong");
   property p_guard; reg_rsp.db_fault |-> dbg_exc.valid && dbg_exc.guard && dbg_exc.fault;
   endproperty
   a_guard: assert property (p_guard) else $error("guard fault without exception");

   // ****************************************************************
   // exceptions
   // ****************************************************************
   property p_step; instr_done && trap_flag |=> dbg_exc.valid && dbg_exc.step; endproperty
   a_step: assert property (p_step) else $error("single step missed");
   property p_task; task_switch && task_trap_bit |=> dbg_exc.valid && dbg_exc.task_trap;
   endproperty
   a_task: assert property (p_task) else $error("task trap missed");
   property p_brk; brk_instr |=> brk_exc; endproperty
   a_brk: assert property (p_brk) else $error("breakpoint instruction missed");
   property p_exc_cause;
      dbg_exc.valid |-> $past(exec_in.valid || data_in.valid || instr_done || task_switch
                              || reg_req.valid);
   endproperty
   a_exc_cause: assert property (p_exc_cause) else $error("exception without cause");

   c_code: cover property (dbg_exc.valid && dbg_exc.fault && dbg_exc.hits != 4'h0);
   c_guard: cover property (reg_rsp.db_fault);
   c_task: cover property (dbg_exc.valid && dbg_exc.task_trap);
endmodule

// file: dv/bdu_tb.sv
`timescale 1ns/1ps
`include "bdu_regs.svh"

module testbench;
   import bdu_pkg::*;
   logic          ref_clk = 1'b0;
   logic          srst = 1'b1;
   bdu_reg_req_s  reg_req;
   logic [1:0]    cpl;
   logic          real_mode;
   bdu_reg_rsp_s  reg_rsp, rsp;
   bdu_exec_s     exec_in;
   bdu_data_s     data_in;
   logic          instr_done, trap_flag, brk_instr, task_switch, task_trap_bit;
   bdu_exc_s      dbg_exc, exc;
   logic          brk_exc, bk;
   int            n_fail = 0;
   int            samples_checked = 0;
   int            seed = 32'h56cb;
   int            cycles = 0;
   logic [31:0]   v, a;
   logic [1:0]    sz;

   // ****************************************************************
   // clock, watchdog, device
   // ****************************************************************
   always #2 ref_clk = ~ref_clk;
   // the data sweep dominates run time; the whole run is about 415 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         wrap_up();
      end
   end

   bdu_debug_unit uut (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .cpl(cpl),
      .real_mode(real_mode), .reg_rsp(reg_rsp), .exec_in(exec_in), .data_in(data_in),
      .instr_done(instr_done), .trap_flag(trap_flag), .brk_instr(brk_instr),
      .task_switch(task_switch), .task_trap_bit(task_trap_bit), .dbg_exc(dbg_exc),
      .brk_exc(brk_exc));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic wrap_up;
      $display("counts: %0d compared, %0d mismatched", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // one move access; an idle edge before each keeps drives single per step
   task automatic reg_op(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
      @(negedge ref_clk);
      reg_req <= '{valid: 1'b1, write: wr, index: idx, wdata: wd};
      @(negedge ref_clk);
      reg_req.valid <= 1'b0;
      rsp = reg_rsp;
   endtask

   // kind: 0 fetch, 1 data (f = size,write), 2 instruction done, 3 task switch, 4 int3
   task automatic ev(input int kind, input logic [31:0] ad, input logic [2:0] f);
      @(negedge ref_clk);
      case (kind)
         0: exec_in <= '{valid: 1'b1, lin_addr: ad};
         1: data_in <= '{valid: 1'b1, write: f[0], size: f[2:1], lin_addr: ad};
         2: instr_done <= 1'b1;
         3: task_switch <= 1'b1;
         default: brk_instr <= 1'b1;
      endcase
      @(negedge ref_clk);
      exec_in.valid <= 1'b0;
      data_in.valid <= 1'b0;
      instr_done <= 1'b0;
      task_switch <= 1'b0;
      brk_instr <= 1'b0;
      exc = dbg_exc;
      bk = brk_exc;
   endtask

   // aligned watch at offset 0; any legal access starting at off overlaps iff off < n
   function automatic logic exp_hit(input logic [1:0] t, input logic [1:0] l, input logic w,
                                    input int off);
      int n;
      n = (l == 2'h0) ? 1 : (l == 2'h1) ? 2 : (l == 2'h3) ? 4 : 0;
      return (t == 2'h3 || (t == 2'h1 && w)) && off < n;
   endfunction

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      reg_req = '0;
      exec_in = '0;
      data_in = '0;
      cpl = 2'h0;
      real_mode = 1'b0;
      {instr_done, trap_flag, brk_instr, task_switch, task_trap_bit} = 5'h00;
      repeat (16) @(negedge ref_clk);
      srst <= 1'b0;
      reg_op(1'b0, 3'h7, '0);
      check(rsp.rdata, 32'h0000_0400, "control reset");
      reg_op(1'b0, 3'h6, '0);
      check(rsp.rdata, 32'h0000_0000, "status reset");
      for (int i = 0; i < 4; i++) begin
         reg_op(1'b0, i[2:0], '0);
         check(rsp.rdata, 32'h0000_0000, "address reset");
         v = $random(seed);
         reg_op(1'b1, i[2:0], v);
         reg_op(1'b0, i[2:0], '0);
         check(rsp.rdata, v, "address register");
      end
      v = $random(seed) & 32'hFFFF_DFFF;
      reg_op(1'b1, 3'h7, v);
      reg_op(1'b0, 3'h7, '0);
      check(rsp.rdata, (v & 32'hFFFF_20FF) | 32'h0000_0400, "control mask");
      reg_op(1'b0, 3'h4, '0);
      check(rsp.rdata, 32'h0000_0000, "unmapped read");
      $display("registers done");
      // privilege: nonzero level refused, real mode always allowed
      a = $random(seed);
      reg_op(1'b1, 3'h0, a);
      cpl <= 2'h1 + 2'(unsigned'($random(seed)) % 3);
      reg_op(1'b1, 3'h0, ~a);
      check({31'h0, rsp.gp_fault}, 32'h1, "privilege fault");
      real_mode <= 1'b1;
      reg_op(1'b0, 3'h0, '0);
      check({31'h0, rsp.gp_fault}, 32'h0, "real mode fault");
      check(rsp.rdata, a, "real mode access");
      cpl <= 2'h0;
      real_mode <= 1'b0;
      $display("privilege done");
      // code breakpoint, disabled twin still flagged
      reg_op(1'b1, 3'h1, a);
      reg_op(1'b1, 3'h7, 32'h0000_0001);
      ev(0, a + 32'h1, 3'h0);
      check({31'h0, exc.valid}, 32'h0, "inexact fetch");
      ev(0, a, 3'h0);
      check({exc.valid, exc.fault, exc.hits}, 6'h33, "code breakpoint");
      reg_op(1'b0, 3'h6, '0);
      check(rsp.rdata, 32'h0000_0003, "hit flags");
      reg_op(1'b1, 3'h6, '0);
      $display("code breakpoint done");
      // task switch with trap bit
      reg_op(1'b1, 3'h7, 32'h0000_00FF);
      task_trap_bit <= 1'b1;
      ev(3, '0, 3'h0);
      task_trap_bit <= 1'b0;
      check({exc.valid, exc.task_trap}, 2'h3, "task trap");
      reg_op(1'b0, 3'h7, '0);
      check(rsp.rdata, 32'h0000_04AA, "enables after switch");
      // single step, then sticky status
      trap_flag <= 1'b1;
      ev(2, '0, 3'h0);
      check({exc.valid, exc.step}, 2'h3, "single step");
      trap_flag <= 1'b0;
      ev(2, '0, 3'h0);
      check({31'h0, exc.valid}, 32'h0, "no step");
      repeat (2) begin
         reg_op(1'b0, 3'h6, '0);
         check(rsp.rdata, 32'h0000_C000, "status kept");
      end
      reg_op(1'b1, 3'h6, '0);
      $display("task and step done");
      // data sweep over every type, length, direction and byte offset
      reg_op(1'b1, 3'h2, 32'h0000_1000);
      for (int c = 0; c < 32; c++) begin
         reg_op(1'b1, 3'h7, 32'h0000_0020 | (32'(c[1:0]) << 24) | (32'(c[3:2]) << 26));
         for (int off = 0; off < 4; off++) begin
            // access size drawn from the three legal codes
            sz = 2'(unsigned'($random(seed)) % 3);
            if (sz == 2'h2) begin
               sz = 2'h3;
            end
            ev(1, 32'h0000_1000 + 32'(off), {sz, c[4]});
            check({exc.valid, exc.hits[2]}, {2{exp_hit(c[1:0], c[3:2], c[4], off)}},
                  "data breakpoint");
         end
      end
      $display("data breakpoints done");
      // guard bit faults the next access and is then cleared
      reg_op(1'b1, 3'h7, 32'h0000_2000);
      reg_op(1'b0, 3'h0, '0);
      check({31'h0, rsp.db_fault}, 32'h1, "guard fault");
      reg_op(1'b0, 3'h7, '0);
      check(rsp.rdata, 32'h0000_0400, "guard cleared");
      ev(4, '0, 3'h0);
      check({31'h0, bk}, 32'h1, "breakpoint instruction");
      $display("guard and int3 done");
      wrap_up();
   end
endmodule

bind bdu_debug_unit bdu_debug_unit_sva chk (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req),
   .cpl(cpl), .real_mode(real_mode), .reg_rsp(reg_rsp), .exec_in(exec_in), .data_in(data_in),
   .instr_done(instr_done), .trap_flag(trap_flag), .brk_instr(brk_instr),
   .task_switch(task_switch), .task_trap_bit(task_trap_bit), .dbg_exc(dbg_exc),
   .brk_exc(brk_exc));
